// [lhm_pkg.sv]
// Package with the constants shared by both ends of the link liveness monitor.
// Assumes one user clock at 10 MHz drives both ends.
package lhm_pkg;

	// User clock period in nanoseconds.
	localparam int unsigned CLOCK_PERIOD_NS = 100;

	// Compensation burst: three cycles high, once every 10,000 cycles.
	localparam int unsigned COMP_BURST_CYCLES = 3;
	localparam int unsigned COMP_PERIOD_CYCLES = 10000;
	localparam logic [13:0] COMP_BURST_LAST = 14'(COMP_BURST_CYCLES - 1);
	localparam logic [13:0] COMP_PERIOD_LAST = 14'(COMP_PERIOD_CYCLES - 1);

	// Least reset hold before removal or power down.
	localparam int unsigned SHUTDOWN_HOLD_CYCLES = 128;
	localparam logic [7:0] SHUTDOWN_HOLD_LAST = 8'(SHUTDOWN_HOLD_CYCLES - 1);

	// Default liveness timeout, two and a half compensation periods.
	localparam int unsigned LIVENESS_TIMEOUT_CYCLES = 25000;

	// Width of the liveness counter.
	localparam int unsigned TIMEOUT_WIDTH = 16;

	// Length of the reset pulse that the monitor issues after a timeout.
	localparam logic [3:0] RECOVERY_PULSE_LAST = 4'hF;

	// Received block kinds as seen on the link.
	typedef enum logic [1:0] {
		LHM_BLK_NONE = 2'h0,
		LHM_BLK_DATA = 2'h1,
		LHM_BLK_COMP = 2'h2,
		LHM_BLK_NOT_READY = 2'h3
	} lhm_block_t;

	// Monitor states, Gray coded along idle, watch, recover.
	typedef enum logic [1:0] {
		LHM_ST_IDLE = 2'h0,
		LHM_ST_WATCH = 2'h1,
		LHM_ST_RECOVER = 2'h3
	} lhm_state_t;

	// Returns true when a received block kind restarts the liveness timeout.
	function automatic logic lhm_is_live(input lhm_block_t kind, input logic rx_only);
		if (rx_only) begin
			return kind != LHM_BLK_NONE;
		end
		return kind == LHM_BLK_COMP;
	endfunction

endpackage

// [lhm_link_if.sv]
// Interface carrying received blocks from the remote partner to the monitor end.
// Assumes both ends share the one user clock.
`timescale 1ns/10ps
interface lhm_link_if;
	import lhm_pkg::*;

	// Block kind and its valid strobe, driven by the remote partner.
	lhm_block_t block_type_code;
	logic block_valid;

	// Remote partner's link-up indication.
	logic remote_link_up;

	// Reset pulses the monitor issues toward the link core and transceiver.
	logic core_reset;
	logic transceiver_reset;

	modport monitor (
		input block_type_code,
		input block_valid,
		input remote_link_up,
		output core_reset,
		output transceiver_reset
	);

	modport partner (
		output block_type_code,
		output block_valid,
		output remote_link_up,
		input core_reset,
		input transceiver_reset
	);
endinterface

// [lhm_monitor.sv]
// Liveness monitor end: watches received blocks and resets the link when they stop.
// Assumes received blocks arrive on the user clock and the partner supplies compensation blocks.
//
// Overview of operation
// - Duplex: compensation blocks prove channel alive.
// - Timeout resets link core and transceiver.
// - Receive-only: any valid block code counts.
// - Enable zero removes all timeout behaviour.
// - Keep the monitor enabled in normal operation.
// - Partner must include the compensation generator.
// - User holds reset 128 cycles before removal.
// - Reset sends not-ready idles; partner drops cleanly.
// - Compensation request: three cycles every 10,000.
// - Never stop compensation while monitor is enabled.
`timescale 1ns/10ps
module lhm_monitor
	import lhm_pkg::*;
#(
	parameter bit LIVENESS_MONITOR_ENABLE = 1'b1,
	parameter bit RX_ONLY_SIMPLEX = 1'b0,
	parameter logic [TIMEOUT_WIDTH-1:0] TIMEOUT_CYCLES = TIMEOUT_WIDTH'(LIVENESS_TIMEOUT_CYCLES)
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// User control.
	input wire logic user_reset,
	// Link side.
	lhm_link_if.monitor link,
	// Status.
	output logic not_ready_idle_blocks,
	output logic link_timed_out,
	output logic monitor_active
);

	lhm_state_t state;
	lhm_state_t next_state;
	logic [TIMEOUT_WIDTH-1:0] idle_count;
	logic [3:0] pulse_count;
	logic core_reset_q;
	logic transceiver_reset_q;

	// State decodes shared by the counters and the timeout test.
	wire in_watch = state == LHM_ST_WATCH;
	wire in_recover = state == LHM_ST_RECOVER;

	// The received block is only trusted when its strobe is high.
	wire live_block = link.block_valid && lhm_is_live(link.block_type_code, RX_ONLY_SIMPLEX);
	wire timeout_hit = in_watch && (idle_count == TIMEOUT_CYCLES);
	wire pulse_done = pulse_count == RECOVERY_PULSE_LAST;

	// Outputs are registered from the next-state decodes, so each one changes on the same edge as the
	// state and none of them trails the state machine by a cycle.
	wire enter_watch = next_state == LHM_ST_WATCH;
	wire enter_recover = next_state == LHM_ST_RECOVER;
	// A user shutdown and a recovery both hold the core and send not-ready idles, so the partner sees
	// the same clean drop either way; only a timeout reaches the transceiver.
	wire link_held = user_reset || enter_recover;

	// A user reset always wins over a pending timeout in the next-state logic, so a shutdown never starts a recovery.
	always_comb begin
		next_state = state;
		case (state)
			LHM_ST_IDLE: begin
				if (LIVENESS_MONITOR_ENABLE && !user_reset) begin
					next_state = LHM_ST_WATCH;
				end
			end
			LHM_ST_WATCH: begin
				if (user_reset) begin
					next_state = LHM_ST_IDLE;
				end else if (timeout_hit) begin
					next_state = LHM_ST_RECOVER;
				end
			end
			LHM_ST_RECOVER: begin
				if (pulse_done) begin
					next_state = LHM_ST_IDLE;
				end
			end
			default: begin
				next_state = LHM_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= LHM_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Counter restarts on every liveness block and holds once the limit is reached.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			idle_count <= '0;
		end else if (!in_watch || live_block) begin
			idle_count <= '0;
		end else if (!timeout_hit) begin
			idle_count <= idle_count + 1'b1;
		end
	end

	// The pulse is timed in its own state, so its length does not depend on when the timeout hit.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pulse_count <= '0;
		end else if (in_recover) begin
			pulse_count <= pulse_count + 1'b1;
		end else begin
			pulse_count <= '0;
		end
	end

	// Both resets are raised on entry to the recovery state so core and transceiver restart together.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			core_reset_q <= 1'b0;
		end else begin
			core_reset_q <= link_held;
		end
	end

	// The transceiver is left alone during a user shutdown; restarting it then would only lengthen
	// the time the partner needs to see the link come back.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			transceiver_reset_q <= 1'b0;
		end else begin
			transceiver_reset_q <= enter_recover;
		end
	end

	// One pulse per timeout, also when a user reset in the same cycle stops the recovery, so pulses count timeouts, not recoveries.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			link_timed_out <= 1'b0;
		end else begin
			link_timed_out <= timeout_hit;
		end
	end

	// A monitor built without the watchdog never reports itself active.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			monitor_active <= 1'b0;
		end else begin
			monitor_active <= enter_watch;
		end
	end

	// While the core is held in reset only not-ready idles leave toward the partner.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			not_ready_idle_blocks <= 1'b0;
		end else begin
			not_ready_idle_blocks <= link_held;
		end
	end

	assign link.core_reset = core_reset_q;
	assign link.transceiver_reset = transceiver_reset_q;

endmodule

// [lhm_partner.sv]
// Remote partner end: sends compensation blocks and drops link-up on not-ready idles.
// Assumes the monitor end shares the user clock; tx_kind and tx_valid stand for the far transmitter.
`timescale 1ns/10ps
module lhm_partner
	import lhm_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// User side.
	input wire logic comp_enable,
	input wire logic data_valid,
	input wire logic far_not_ready,
	input wire logic user_reset_request,
	// Link side.
	lhm_link_if.partner link,
	// Status.
	output logic send_comp_request,
	output logic user_reset,
	output logic link_up,
	output logic soft_error
);

	logic [13:0] period_count;
	logic [7:0] hold_count;
	logic hold_done;
	lhm_block_t tx_kind;
	logic tx_valid;

	// Compensation runs while enabled; stopping it with the monitor on causes resets.
	wire comp_window = comp_enable && (period_count <= COMP_BURST_LAST);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			period_count <= '0;
		end else if (period_count == COMP_PERIOD_LAST) begin
			period_count <= '0;
		end else begin
			period_count <= period_count + 1'b1;
		end
	end

	// Reset is held for the full shutdown time even if the request is short.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hold_count <= '0;
			hold_done <= 1'b1;
		end else if (user_reset_request) begin
			hold_count <= '0;
			hold_done <= 1'b0;
		end else if (!hold_done) begin
			hold_count <= hold_count + 1'b1;
			hold_done <= hold_count == SHUTDOWN_HOLD_LAST;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			send_comp_request <= 1'b0;
			user_reset <= 1'b0;
			tx_kind <= LHM_BLK_NONE;
			tx_valid <= 1'b0;
			link_up <= 1'b0;
			soft_error <= 1'b0;
		end else begin
			send_comp_request <= comp_window;
			user_reset <= user_reset_request || !hold_done;
			tx_valid <= comp_window || data_valid || far_not_ready;
			tx_kind <= comp_window ? LHM_BLK_COMP : (far_not_ready ? LHM_BLK_NOT_READY :
				(data_valid ? LHM_BLK_DATA : LHM_BLK_NONE));
			// Not-ready idles take the link down without counting as an error.
			link_up <= !far_not_ready && !link.core_reset;
			soft_error <= 1'b0;
		end
	end

	assign link.block_type_code = tx_kind;
	assign link.block_valid = tx_valid;
	assign link.remote_link_up = link_up;

endmodule

// [lhm_assertions.sv]
// Concurrent checks on the link between the monitor and partner ends.
// Assumes one clock; the timeout comes in as a parameter.
`timescale 1ns/10ps
module lhm_assertions
	import lhm_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = 25000
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Link.
	input wire lhm_block_t block_type_code,
	input wire logic block_valid,
	input wire logic remote_link_up,
	input wire logic core_reset,
	input wire logic transceiver_reset
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic comp_q;
	logic seen;
	int idle;
	int gap;
	int run;
	wire comp = block_valid && block_type_code == LHM_BLK_COMP;
	wire comp_rise = comp && !comp_q;
	// The idle count restarts on any core reset, so after a recovery it runs one cycle ahead of the monitor's own count.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			comp_q <= 1'b0;
			seen <= 1'b0;
			idle <= 0;
			gap <= 0;
			run <= 0;
		end else begin
			comp_q <= comp;
			seen <= seen | comp_rise;
			idle <= (core_reset || comp) ? 0 : idle + 1;
			gap <= comp_rise ? 0 : gap + 1;
			run <= transceiver_reset ? run + 1 : 0;
		end
	end
	sequence burst_s;
		comp [*3] ##1 !comp;
	endsequence
	chk_comp_burst: assert property ($rose(comp) |-> burst_s) else $error("bad burst length");
	chk_comp_period: assert property (comp_rise && seen |-> gap % 10000 == 9999) else $error("bad burst period");
	chk_reset_pair: assert property ($rose(transceiver_reset) |-> core_reset) else $error("core reset missing");
	chk_recover_len: assert property ($fell(transceiver_reset) |-> run == 16) else $error("bad recovery length");
	chk_timeout_early: assert property ($rose(transceiver_reset) |-> idle >= TIMEOUT_CYCLES) else $error("early reset");
	chk_timeout_late: assert property (idle <= TIMEOUT_CYCLES + 4) else $error("timeout missed");
	chk_link_drop: assert property ($rose(core_reset) |-> ##[1:4] !remote_link_up) else $error("link kept up");
	chk_link_hold: assert property (core_reset [*2] |-> !remote_link_up) else $error("link up in reset");
endmodule

// [tb.sv]
// Testbench joining monitor and partner, with a disabled and a receive-only monitor beside them.
// Assumes the 10,000-cycle compensation schedule and a shortened timeout.
`timescale 1ns/10ps
module tb;
	import lhm_pkg::*;
	localparam int TO = 12000;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic comp_enable = 1'b0;
	logic data_valid = 1'b0;
	logic user_reset_request = 1'b0;
	logic far_not_ready = 1'b0;
	logic comp_req;
	logic active;
	int n_req = 0;
	int n_idle = 0;
	int n_down = 0;
	logic user_reset;
	logic soft_error;
	logic nri;
	logic [2:0] timed_out;
	int n_errors = 0;
	int comparisons = 0;
	int n_to[3] = '{default: 0};
	int n_ur = 0;
	int n_nri = 0;
	int n_soft = 0;
	int len;
	lhm_link_if lk();
	lhm_link_if lk2();
	lhm_link_if lk3();
	assign lk2.block_type_code = lk.block_type_code;
	assign lk2.block_valid = lk.block_valid;
	assign lk2.remote_link_up = lk.remote_link_up;
	assign lk3.block_type_code = lk.block_type_code;
	assign lk3.block_valid = lk.block_valid;
	assign lk3.remote_link_up = lk.remote_link_up;
	lhm_partner lhm_partner_i (.clock(clock), .rst_n(rst_n), .comp_enable(comp_enable), .data_valid(data_valid),
		.far_not_ready(far_not_ready), .user_reset_request(user_reset_request), .link(lk.partner),
		.send_comp_request(comp_req), .user_reset(user_reset), .link_up(), .soft_error(soft_error));
	lhm_monitor #(.TIMEOUT_CYCLES(16'(TO))) lhm_monitor_i (.clock(clock), .rst_n(rst_n), .user_reset(user_reset),
		.link(lk.monitor), .not_ready_idle_blocks(nri), .link_timed_out(timed_out[0]), .monitor_active(active));
	lhm_monitor #(.LIVENESS_MONITOR_ENABLE(1'b0), .TIMEOUT_CYCLES(16'(TO))) lhm_monitor_i2 (.clock(clock),
		.rst_n(rst_n), .user_reset(user_reset), .link(lk2.monitor), .not_ready_idle_blocks(),
		.link_timed_out(timed_out[1]), .monitor_active());
	lhm_monitor #(.RX_ONLY_SIMPLEX(1'b1), .TIMEOUT_CYCLES(16'(TO))) lhm_monitor_i3 (.clock(clock), .rst_n(rst_n),
		.user_reset(user_reset), .link(lk3.monitor), .not_ready_idle_blocks(), .link_timed_out(timed_out[2]),
		.monitor_active());
	lhm_assertions #(.TIMEOUT_CYCLES(TO)) lhm_assertions_i (.clock(clock), .rst_n(rst_n),
		.block_type_code(lk.block_type_code), .block_valid(lk.block_valid), .remote_link_up(lk.remote_link_up),
		.core_reset(lk.core_reset), .transceiver_reset(lk.transceiver_reset));
	initial begin
		forever #50 clock = ~clock;
	end
	always @(posedge clock) data_valid <= 1'($urandom_range(1, 0));
	// Counting on the falling edge keeps clear of the registered outputs' update.
	always @(negedge clock) begin
		for (int k = 0; k < 3; k++) n_to[k] += int'(timed_out[k] === 1'b1);
		n_ur += int'(user_reset === 1'b1);
		n_nri += int'(nri === 1'b1);
		n_soft += int'(soft_error === 1'b1);
		n_req += int'(comp_req === 1'b1);
		n_idle += int'(active === 1'b0);
		n_down += int'(lk.remote_link_up === 1'b0);
	end
	// Phases with compensation on start at the head of a compensation period.
	function automatic int exp_requests(int cycles, logic comp_on);
		int periods;
		periods = (cycles + int'(COMP_PERIOD_CYCLES) - 1) / int'(COMP_PERIOD_CYCLES);
		return comp_on ? periods * int'(COMP_BURST_CYCLES) : 0;
	endfunction
	// A recovery takes the timeout plus about 18 cycles of reset pulse and restart.
	function automatic int exp_timeouts(int cycles, logic comp_on);
		return comp_on ? 0 : cycles / (TO + 18);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %0d expected %0d", $time, seen, exp);
		end
	endtask
	task automatic run_phase(int cycles, logic comp_on);
		n_to = '{default: 0};
		n_req = 0;
		repeat (cycles) @(posedge clock);
		check(n_to[0], exp_timeouts(cycles, comp_on));
		check(n_req, exp_requests(cycles, comp_on));
		check(n_to[1], 0);
		check(n_to[2], 0);
	endtask
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#(90000 * 100);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(48));
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		comp_enable <= 1'b1;
		run_phase(25000, 1'b1);
		// Found on a clock edge, so compensation is switched off just after a whole burst has gone out.
		@(posedge clock iff (lk.block_valid === 1'b1 && lk.block_type_code == LHM_BLK_COMP));
		repeat (3) @(posedge clock);
		comp_enable <= 1'b0;
		run_phase(30000, 1'b0);
		rst_n <= 1'b0;
		comp_enable <= 1'b1;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (50) @(posedge clock);
		len = $urandom_range(4, 1);
		n_ur = 0;
		n_nri = 0;
		n_idle = 0;
		user_reset_request <= 1'b1;
		repeat (len) @(posedge clock);
		user_reset_request <= 1'b0;
		repeat (300) @(posedge clock);
		check(n_ur, len + SHUTDOWN_HOLD_CYCLES);
		check(n_nri, len + SHUTDOWN_HOLD_CYCLES);
		check(n_idle, len + SHUTDOWN_HOLD_CYCLES);
		n_down = 0;
		far_not_ready <= 1'b1;
		repeat (len) @(posedge clock);
		far_not_ready <= 1'b0;
		repeat (4) @(posedge clock);
		check(n_down, len);
		check(n_soft, 0);
		tally_and_finish();
	end
endmodule
